// ===== logic/dmc_pkg.sv
// shared constants for the dac mode configuration and power-up block
package dmc_pkg;
	// ==========================================================
	// timing
	localparam int          CLK_MHZ          = 200;
	localparam int          STARTUP_CYCLES   = 262144;        // two to the eighteenth master clocks
	localparam int          STARTUP_W        = 19;
	localparam int          RATIO_W          = 12;
	localparam logic [11:0] RATIO_SAT        = 12'hfff;
	localparam logic [7:0]  ZERO_FRAMES      = 8'h80;         // static zero frames before auto-mute
	// ==========================================================
	// control register indices and fields
	localparam logic [3:0]  REG_STATUS       = 4'h1;
	localparam logic [3:0]  REG_MODE         = 4'h2;
	localparam logic [3:0]  REG_MUTE         = 4'h4;
	localparam logic [3:0]  REG_POWER        = 4'h8;
	localparam int          SPD_LSB          = 0;             // speed_mode_field [1:0] of REG_MODE
	localparam int          FMT_LSB          = 2;             // audio_format_field [4:2] of REG_MODE
	localparam int          PDN_BIT          = 0;             // power_down_bit of REG_POWER
	localparam int          DIV2_BIT         = 4;             // master_divider_sel of REG_POWER
	localparam int          DIV3_BIT         = 5;
	localparam int          CONTROL_ENABLE_BIT_BIT         = 7;             // control_enable_bit of REG_POWER
	localparam logic [7:0]  MODE_DEFAULT     = 8'h00;
	localparam logic [7:0]  MUTE_DEFAULT     = 8'h00;
	localparam logic [7:0]  POWER_DEFAULT    = 8'h01;         // powered down, control disabled
	// ==========================================================
	// encodings
	localparam logic [1:0]  SPD_SINGLE       = 2'h0;
	localparam logic [1:0]  SPD_DOUBLE       = 2'h1;
	localparam logic [1:0]  SPD_QUAD         = 2'h2;
	localparam logic [2:0]  FMT_LJ24         = 3'h0;
	localparam logic [2:0]  FMT_I2S24        = 3'h1;
	localparam logic [2:0]  FMT_RJ16         = 3'h2;
	localparam logic [2:0]  FMT_RJ24         = 3'h3;
	localparam logic [2:0]  FMT_RJ20         = 3'h4;
	localparam logic [2:0]  FMT_RJ18         = 3'h5;
	localparam logic [1:0]  MPOL_ACT_LOW     = 2'h1;
	localparam logic [1:0]  MPOL_ACT_HIGH    = 2'h2;
	localparam logic [7:0]  OSR_SINGLE       = 8'h80;
	localparam logic [7:0]  OSR_DOUBLE       = 8'h40;
	localparam logic [7:0]  OSR_QUAD         = 8'h20;
	localparam logic [7:0]  ATTEN_MUTE       = 8'hff;         // attenuation in eighth-decibel steps
	localparam logic [7:0]  ATTEN_0DB        = 8'h00;
	// ==========================================================
	// host apb map
	localparam logic [7:0]  APB_CP_CMD       = 8'h00;         // [11:8] addr, [7:0] data, [12] write
	localparam logic [7:0]  APB_CP_RDATA     = 8'h04;
	localparam logic [7:0]  APB_STRAP        = 8'h08;         // [3:0] strap pins
	localparam logic [7:0]  APB_AUDIO        = 8'h0c;         // [0] release serial audio line
	localparam logic [7:0]  APB_FRAME_DIV    = 8'h10;         // half frame period in clocks
	localparam int          CMD_WR_BIT       = 12;
	localparam logic [15:0] FRAME_DIV_RESET  = 16'h0080;
endpackage

// ===== logic/dmc_if.sv
// link between the host controller and the dac configuration end
`timescale 1ns/1ps
interface dmc_if;
	logic [3:0] strap_pin;          // strap_pin_3..strap_pin_0
	logic       cp_wr;              // control write strobe
	logic [3:0] cp_addr;
	logic [7:0] cp_wdata;
	logic [7:0] cp_rdata;
	logic       frame_clock;
	logic       serial_audio_line;
	logic [1:0] mute_output_o;
	logic [1:0] mute_output_oe;
	logic [1:0] mute_bias;          // external mute circuit self-bias
	logic [1:0] mute_line;

	genvar g;
	for (g = 0; g < 2; g++) begin : g_mute
		assign mute_line[g] = mute_output_oe[g] ? mute_output_o[g] : mute_bias[g];
	end

	modport dev (input strap_pin, cp_wr, cp_addr, cp_wdata, frame_clock, serial_audio_line, mute_line,
		output cp_rdata, mute_output_o, mute_output_oe);
	modport host (output strap_pin, cp_wr, cp_addr, cp_wdata, frame_clock, serial_audio_line, mute_bias,
		input cp_rdata, mute_line);
endinterface

// ===== logic/dmc_host.sv
// host end: apb-programmed strap pins, control writes, frame clock and audio gating
`timescale 1ns/1ps
module dmc_host (
	input  wire logic        sys_clk_in,      // 200 mhz
	input  wire logic        reset_in,        // async, active high
	input  wire logic        psel_in,         // apb select
	input  wire logic        penable_in,      // apb enable
	input  wire logic        pwrite_in,       // apb direction
	input  wire logic [7:0]  paddr_in,        // apb byte address
	input  wire logic [31:0] pwdata_in,       // apb write data
	output logic      [31:0] prdata_out,      // apb read data
	output logic             pready_out,      // apb ready
	output logic             pslverr_out,     // apb error
	input  wire logic        audio_bit_in,    // user serial audio bit
	input  wire logic [1:0]  mute_bias_in,    // board bias level of mute lines
	dmc_if.host              link             // to the dac end
);
	logic [3:0]  strap_ff;
	logic        wr_ff;
	logic [3:0]  addr_ff;
	logic [7:0]  wdata_ff;
	logic        audio_en_ff;
	logic [15:0] div_ff;
	logic [15:0] half_cnt_ff;
	logic        frame_ff;
	logic        audio_ff;
	logic        acc;
	logic        hit;

	assign acc         = psel_in && penable_in;
	assign pready_out  = 1'b1;
	assign hit         = (paddr_in == dmc_pkg::APB_CP_CMD) || (paddr_in == dmc_pkg::APB_CP_RDATA) ||
		(paddr_in == dmc_pkg::APB_STRAP) || (paddr_in == dmc_pkg::APB_AUDIO) ||
		(paddr_in == dmc_pkg::APB_FRAME_DIV);
	assign pslverr_out = acc && !hit;

	// ==========================================================
	// registers
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			strap_ff    <= 4'h0;
			audio_en_ff <= 1'b0;
			div_ff      <= dmc_pkg::FRAME_DIV_RESET;
			addr_ff     <= 4'h0;
			wdata_ff    <= 8'h00;
		end else if (acc && pwrite_in) begin
			case (paddr_in)
				dmc_pkg::APB_CP_CMD: begin
					addr_ff  <= pwdata_in[11:8];
					wdata_ff <= pwdata_in[7:0];
				end
				dmc_pkg::APB_STRAP:     strap_ff    <= pwdata_in[3:0];
				dmc_pkg::APB_AUDIO:     audio_en_ff <= pwdata_in[0];
				dmc_pkg::APB_FRAME_DIV: div_ff      <= pwdata_in[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			wr_ff <= 1'b0;
		else
			wr_ff <= acc && pwrite_in && (paddr_in == dmc_pkg::APB_CP_CMD) && pwdata_in[dmc_pkg::CMD_WR_BIT];
	end

	always_comb begin
		case (paddr_in)
			dmc_pkg::APB_CP_CMD:    prdata_out = {20'h0, addr_ff, wdata_ff};
			dmc_pkg::APB_CP_RDATA:  prdata_out = {24'h0, link.cp_rdata};
			dmc_pkg::APB_STRAP:     prdata_out = {28'h0, strap_ff};
			dmc_pkg::APB_AUDIO:     prdata_out = {29'h0, link.mute_line, audio_en_ff};
			dmc_pkg::APB_FRAME_DIV: prdata_out = {16'h0, div_ff};
			default:                prdata_out = 32'h0;
		endcase
	end

	// ==========================================================
	// frame clock and audio line
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			half_cnt_ff <= 16'h0;
			frame_ff    <= 1'b0;
		end else if (half_cnt_ff + 16'h1 >= div_ff) begin
			half_cnt_ff <= 16'h0;
			frame_ff    <= !frame_ff;
		end else begin
			half_cnt_ff <= half_cnt_ff + 16'h1;
		end
	end

	// line stays static zero until software declares the dac configured
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			audio_ff <= 1'b0;
		else
			audio_ff <= audio_en_ff && audio_bit_in;
	end

	assign link.strap_pin         = strap_ff;
	assign link.cp_wr             = wr_ff;
	assign link.cp_addr           = addr_ff;
	assign link.cp_wdata          = wdata_ff;
	assign link.frame_clock       = frame_ff;
	assign link.serial_audio_line = audio_ff;
	assign link.mute_bias         = mute_bias_in;
endmodule

// ===== logic/dmc_dev.sv
// dac end: strap decode, start-up window, control takeover, ratio check, mute and volume ramp
// Operation
// - master clock phase to frame clock is free
// - single speed ratios 256/384/512, more with divider
// - double speed ratios 128..384, 512 with divider
// - divider select exists only under register control
// - format straps: LJ, I2S, RJ16, RJ24
// - speed straps: single, single+de-emph, double, quad
// - strap mode: auto-mute, auto polarity, fast filter
// - strap mode: eighth-dB volume ramp per frame
// - strap mode lacks register-only features
// - reset holds registers at defaults
// - low power, strap start after 2^18 clocks
// - control enable before start halts, resets registers
// - clearing power-down starts power-up
// - missed window starts strap mode
// - host holds audio zero after missed window
// - register speed field selects speed
// - register format field selects format
// - register mute polarity overrides detected polarity
// - oversample 128x, 64x, 32x by speed
// - mute lines released in reset, sampled after
`timescale 1ns/1ps
module dmc_dev #(
	parameter int STARTUP_CYCLES = dmc_pkg::STARTUP_CYCLES   // shorten for simulation
) (
	input  wire logic       sys_clk_in,      // master clock, 200 mhz
	input  wire logic       reset_in,        // async, active high
	dmc_if.dev              link,            // to the host
	output logic            running_out,     // converting
	output logic            ctrl_mode_out,   // register control active
	output logic [1:0]      speed_out,       // effective speed mode
	output logic [2:0]      format_out,      // effective audio format
	output logic            deemph_out,      // 44.1 khz de-emphasis on
	output logic            auto_mute_out,   // auto-mute on zero data enabled
	output logic            fast_filter_out, // fast roll-off filter selected
	output logic [7:0]      osr_out,         // oversampling ratio
	output logic [7:0]      atten_out,       // attenuation, eighth-db steps
	output logic            ratio_ok_out,    // measured ratio legal
	output logic [11:0]     ratio_out        // measured master clocks per frame
);
	typedef enum logic [2:0] {ST_WAIT, ST_STRAP, ST_CTRL_PDN, ST_CTRL_RUN} dmc_state_t;

	localparam int           STARTUP_W = dmc_pkg::STARTUP_W;
	dmc_state_t              state_ff;
	logic [STARTUP_W-1:0]    start_cnt_ff;
	logic [7:0]              mode_ff;
	logic [7:0]              mute_ff;
	logic [7:0]              power_ff;
	logic [3:0]              strap_ff;
	logic [7:0]              rdata_ff;
	logic                    det_done_ff;
	logic [1:0]              det_pol_ff;
	logic                    frame_d_ff;
	logic [11:0]             cnt_ff;
	logic [11:0]             ratio_ff;
	logic                    one_seen_ff;
	logic [7:0]              zero_cnt_ff;
	logic [7:0]              atten_ff;
	logic                    frame_rise;
	logic                    control_enable_bit_wr;
	logic                    window_end;
	logic                    strap_mode;
	logic                    div_on;
	logic [1:0]              spd;
	logic [2:0]              fmt;
	logic                    muted;
	logic [1:0]              act_pol;

	assign frame_rise = link.frame_clock && !frame_d_ff;
	assign control_enable_bit_wr    = link.cp_wr && (link.cp_addr == dmc_pkg::REG_POWER) && link.cp_wdata[dmc_pkg::CONTROL_ENABLE_BIT_BIT];
	assign window_end = (start_cnt_ff == STARTUP_W'(STARTUP_CYCLES - 1));
	assign strap_mode = (state_ff == ST_STRAP);

	// ==========================================================
	// start-up sequencing
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_ff     <= ST_WAIT;
			start_cnt_ff <= '0;
		end else begin
			case (state_ff)
				ST_WAIT: begin
					start_cnt_ff <= start_cnt_ff + STARTUP_W'(1);
					if (control_enable_bit_wr)
						state_ff <= ST_CTRL_PDN;
					else if (window_end)
						state_ff <= ST_STRAP;
				end
				ST_STRAP: begin
					if (control_enable_bit_wr)
						state_ff <= ST_CTRL_PDN;
				end
				ST_CTRL_PDN: begin
					if (!power_ff[dmc_pkg::CONTROL_ENABLE_BIT_BIT])
						state_ff <= ST_STRAP;
					else if (!power_ff[dmc_pkg::PDN_BIT])
						state_ff <= ST_CTRL_RUN;
				end
				ST_CTRL_RUN: begin
					if (power_ff[dmc_pkg::PDN_BIT])
						state_ff <= ST_CTRL_PDN;
				end
				default: state_ff <= ST_WAIT;
			endcase
		end
	end

	// straps caught once as strap start-up begins, kept until reset
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			strap_ff <= 4'h0;
		else if (state_ff == ST_WAIT && window_end && !control_enable_bit_wr)
			strap_ff <= link.strap_pin;
	end

	// ==========================================================
	// control registers; only the power register listens before control is enabled
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			mode_ff  <= dmc_pkg::MODE_DEFAULT;
			mute_ff  <= dmc_pkg::MUTE_DEFAULT;
			power_ff <= dmc_pkg::POWER_DEFAULT;
		end else if (control_enable_bit_wr && !ctrl_mode_out) begin
			mode_ff  <= dmc_pkg::MODE_DEFAULT;
			mute_ff  <= dmc_pkg::MUTE_DEFAULT;
			power_ff <= link.cp_wdata;
		end else if (link.cp_wr && (ctrl_mode_out || link.cp_addr == dmc_pkg::REG_POWER)) begin
			case (link.cp_addr)
				dmc_pkg::REG_MODE:  mode_ff  <= link.cp_wdata;
				dmc_pkg::REG_MUTE:  mute_ff  <= link.cp_wdata;
				dmc_pkg::REG_POWER: power_ff <= link.cp_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			rdata_ff <= 8'h00;
		else begin
			case (link.cp_addr)
				dmc_pkg::REG_STATUS: rdata_ff <= {2'h0, det_pol_ff, ratio_ok_out, 3'(state_ff)};
				dmc_pkg::REG_MODE:   rdata_ff <= mode_ff;
				dmc_pkg::REG_MUTE:   rdata_ff <= mute_ff;
				dmc_pkg::REG_POWER:  rdata_ff <= power_ff;
				default:             rdata_ff <= 8'h00;
			endcase
		end
	end
	assign link.cp_rdata = rdata_ff;

	// ==========================================================
	// effective configuration
	assign ctrl_mode_out = (state_ff == ST_CTRL_PDN) || (state_ff == ST_CTRL_RUN);
	assign running_out   = strap_mode || (state_ff == ST_CTRL_RUN);
	// divider ignored outside register control
	assign div_on        = ctrl_mode_out &&
		(power_ff[dmc_pkg::DIV2_BIT] || power_ff[dmc_pkg::DIV3_BIT]);

	always_comb begin
		if (ctrl_mode_out) begin
			spd = mode_ff[dmc_pkg::SPD_LSB +: 2];
			fmt = mode_ff[dmc_pkg::FMT_LSB +: 3];
		end else begin
			fmt = {1'b0, strap_ff[1:0]};
			case (strap_ff[3:2])
				2'h2:    spd = dmc_pkg::SPD_DOUBLE;
				2'h3:    spd = dmc_pkg::SPD_QUAD;
				default: spd = dmc_pkg::SPD_SINGLE;
			endcase
		end
	end
	assign speed_out       = spd;
	assign format_out      = fmt;
	assign deemph_out      = strap_mode && (strap_ff[3:2] == 2'h1);
	assign auto_mute_out   = strap_mode;
	assign fast_filter_out = strap_mode;

	always_comb begin
		case (spd)
			dmc_pkg::SPD_DOUBLE: osr_out = dmc_pkg::OSR_DOUBLE;
			dmc_pkg::SPD_QUAD:   osr_out = dmc_pkg::OSR_QUAD;
			default:             osr_out = dmc_pkg::OSR_SINGLE;
		endcase
	end

	// ==========================================================
	// ratio measurement; frame edges are only counted, so no phase relation is needed
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			frame_d_ff <= 1'b0;
			cnt_ff     <= 12'h0;
			ratio_ff   <= 12'h0;
		end else begin
			frame_d_ff <= link.frame_clock;
			if (frame_rise) begin
				cnt_ff   <= 12'h1;
				ratio_ff <= cnt_ff;
			end else if (cnt_ff != dmc_pkg::RATIO_SAT)
				cnt_ff <= cnt_ff + 12'h1;
		end
	end
	assign ratio_out = ratio_ff;

	always_comb begin
		case (spd)
			dmc_pkg::SPD_SINGLE: ratio_ok_out = (ratio_ff == 12'h100) || (ratio_ff == 12'h180) ||
				(ratio_ff == 12'h200) || (div_on && ((ratio_ff == 12'h300) || (ratio_ff == 12'h400) ||
				(ratio_ff == 12'h480)));
			dmc_pkg::SPD_DOUBLE: ratio_ok_out = (ratio_ff == 12'h080) || (ratio_ff == 12'h0c0) ||
				(ratio_ff == 12'h100) || (ratio_ff == 12'h180) || (div_on && ratio_ff == 12'h200);
			dmc_pkg::SPD_QUAD:   ratio_ok_out = (ratio_ff == 12'h060) || (ratio_ff == 12'h080) ||
				(ratio_ff == 12'h0c0) || (ratio_ff == 12'h040 && fmt == dmc_pkg::FMT_RJ16) ||
				(div_on && ratio_ff == 12'h100);
			default:             ratio_ok_out = 1'b0;
		endcase
	end

	// ==========================================================
	// mute polarity: lines undriven in reset, level caught on the first edge after release
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			det_done_ff <= 1'b0;
			det_pol_ff  <= 2'h0;
		end else if (!det_done_ff) begin
			det_done_ff <= 1'b1;
			det_pol_ff  <= link.mute_line;
		end
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			one_seen_ff <= 1'b0;
			zero_cnt_ff <= 8'h00;
		end else if (frame_rise) begin
			one_seen_ff <= link.serial_audio_line;
			if (one_seen_ff)
				zero_cnt_ff <= 8'h00;
			else if (zero_cnt_ff != dmc_pkg::ZERO_FRAMES)
				zero_cnt_ff <= zero_cnt_ff + 8'h01;
		end else if (link.serial_audio_line)
			one_seen_ff <= 1'b1;
	end

	assign muted = !running_out || (auto_mute_out && zero_cnt_ff == dmc_pkg::ZERO_FRAMES);
	assign act_pol = (ctrl_mode_out && mute_ff[1:0] == dmc_pkg::MPOL_ACT_LOW)  ? 2'h0 :
		(ctrl_mode_out && mute_ff[1:0] == dmc_pkg::MPOL_ACT_HIGH) ? 2'h3 : det_pol_ff;
	assign link.mute_output_oe = {2{det_done_ff}};
	assign link.mute_output_o  = muted ? act_pol : ~act_pol;

	// ==========================================================
	// strap-mode soft ramp; a change of measured ratio restarts it
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			atten_ff <= dmc_pkg::ATTEN_MUTE;
		else if (!strap_mode)
			atten_ff <= ctrl_mode_out ? dmc_pkg::ATTEN_0DB : dmc_pkg::ATTEN_MUTE;
		else if (frame_rise && cnt_ff != ratio_ff && ratio_ff != 12'h0)
			atten_ff <= dmc_pkg::ATTEN_MUTE;
		else if (frame_rise && atten_ff != dmc_pkg::ATTEN_0DB)
			atten_ff <= atten_ff - 8'h01;
	end
	assign atten_out = atten_ff;
endmodule

// ===== bench/dmc_link_asserts.sv
// concurrent checks on the link between the host end and the dac end
`timescale 1ns/1ps
module dmc_link_asserts (
	input  wire logic       sys_clk_in,        // master clock
	input  wire logic       reset_in,          // async, active high
	input  wire logic       cp_wr,             // control write strobe
	input  wire logic [3:0] cp_addr,           // control register index
	input  wire logic [7:0] cp_wdata,          // control write data
	input  wire logic [7:0] cp_rdata,          // control read data
	input  wire logic       frame_clock,       // frame clock
	input  wire logic       serial_audio_line, // serial audio data
	input  wire logic [1:0] mute_output_oe,    // mute drive enables
	input  wire logic [1:0] mute_line          // resolved mute lines
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);
	// ==========================================================
	// sequences
	sequence s_release;
		$fell(reset_in);
	endsequence
	sequence s_pwr_wr;
		cp_wr && cp_addr == dmc_pkg::REG_POWER && cp_wdata[dmc_pkg::CONTROL_ENABLE_BIT_BIT];
	endsequence
	sequence s_mode_idle;
		(cp_addr == dmc_pkg::REG_MODE && !cp_wr) [*3];
	endsequence
	// ==========================================================
	// assertions
	oe_release_a: assert property (
		s_release |-> mute_output_oe == 2'h0 ##1 (mute_output_oe == 2'h3 && mute_line == $past(mute_line)))
		else $error("mute lines not taken over at reset release");
	oe_hold_a: assert property (mute_output_oe == 2'h3 |=> mute_output_oe == 2'h3)
		else $error("mute drive dropped");
	rdata_reset_a: assert property (s_release |-> cp_rdata == 8'h00)
		else $error("read data not cleared by reset");
	power_rdback_a: assert property (
		s_pwr_wr ##1 cp_addr == dmc_pkg::REG_POWER |=> cp_addr != dmc_pkg::REG_POWER || cp_rdata == $past(cp_wdata, 2))
		else $error("power register write not taken");
	wr_pulse_a: assert property (cp_wr |=> !cp_wr)
		else $error("control write strobe longer than one cycle");
	audio_quiet_a: assert property (s_release |-> !serial_audio_line [*8])
		else $error("audio line not held low after reset");
	frame_half_a: assert property ($changed(frame_clock) |=> $stable(frame_clock) [*3])
		else $error("frame clock half period too short");
	mode_hold_a: assert property (s_mode_idle |=> $stable(cp_rdata))
		else $error("mode register changed without a write");
endmodule

// ===== bench/dac_mode_config_powerup_test.sv
// self-checking bench for the host and dac ends joined by the link
`timescale 1ns/1ps
module dac_mode_config_powerup_test;
	localparam int SU = 64;
	logic        sys_clk_in, reset_in, psel, penable, pwrite, pready, pslverr, audio_bit, e;
	logic [7:0]  paddr, osr, atten;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  mute_bias, speed, x_spd;
	logic [2:0]  format;
	logic        running, ctrl_mode, deemph, auto_mute, fast_filter, ratio_ok;
	logic [11:0] ratio;
	int          errors, n_tests, k, i;
	int          cyc = 0;
	logic [1:0]  t_spd [6] = '{dmc_pkg::SPD_QUAD, dmc_pkg::SPD_QUAD, dmc_pkg::SPD_QUAD, dmc_pkg::SPD_DOUBLE,
		dmc_pkg::SPD_SINGLE, dmc_pkg::SPD_SINGLE};
	logic [7:0]  t_half [6] = '{8'h80, 8'h20, 8'h20, 8'h40, 8'h40, 8'hc0};
	logic [2:0]  t_fmt [6] = '{dmc_pkg::FMT_RJ20, dmc_pkg::FMT_RJ20, dmc_pkg::FMT_RJ16, dmc_pkg::FMT_RJ20,
		dmc_pkg::FMT_RJ20, dmc_pkg::FMT_RJ20};
	logic        t_ok [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
	dmc_if link ();
	dmc_host i_dmc_host (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .audio_bit_in(audio_bit), .mute_bias_in(mute_bias), .link(link));
	// short start-up window so each reset costs tens of cycles
	dmc_dev #(.STARTUP_CYCLES(SU)) i_dmc_dev (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link(link),
		.running_out(running), .ctrl_mode_out(ctrl_mode), .speed_out(speed), .format_out(format),
		.deemph_out(deemph), .auto_mute_out(auto_mute), .fast_filter_out(fast_filter), .osr_out(osr),
		.atten_out(atten), .ratio_ok_out(ratio_ok), .ratio_out(ratio));
	dmc_link_asserts i_dmc_link_asserts (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .cp_wr(link.cp_wr),
		.cp_addr(link.cp_addr), .cp_wdata(link.cp_wdata), .cp_rdata(link.cp_rdata), .frame_clock(link.frame_clock),
		.serial_audio_line(link.serial_audio_line), .mute_output_oe(link.mute_output_oe), .mute_line(link.mute_line));
	initial begin
		sys_clk_in = 1'b0;
		forever #2.5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) cyc <= reset_in ? 0 : cyc + 1;
	// ==========================================================
	// tasks
	task automatic give_verdict;
		if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			errors++;
			$display("ERROR %0t wait timed out", $time);
			give_verdict();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic er);
		int n;
		@(posedge sys_clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (pready !== 1'b1 && n < 50);
		tmo(n, 50);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        er;
		apb(1'b1, a, d, r, er);
	endtask
	task automatic cpw(input logic [3:0] a, input logic [7:0] d);
		wr(dmc_pkg::APB_CP_CMD, {19'h0, 1'b1, a, d});
		repeat (3) @(posedge sys_clk_in);
	endtask
	task automatic cprd(input logic [3:0] a, output logic [31:0] r);
		logic er;
		wr(dmc_pkg::APB_CP_CMD, {20'h0, a, 8'h00});
		repeat (2) @(posedge sys_clk_in);
		apb(1'b0, dmc_pkg::APB_CP_RDATA, 32'h0, r, er);
	endtask
	task automatic rst(input logic [1:0] bias);
		mute_bias <= bias;
		reset_in <= 1'b1;
		repeat (12) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{reset_in, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		audio_bit = 1'b1;
		mute_bias = 2'h0;
		errors = 0;
		n_tests = 0;
		// strap start-up for every speed and format code
		for (i = 0; i < 4; i++) begin
			rst(2'h0);
			x_spd = i < 2 ? dmc_pkg::SPD_SINGLE : i == 2 ? dmc_pkg::SPD_DOUBLE : dmc_pkg::SPD_QUAD;
			wr(dmc_pkg::APB_STRAP, {28'h0, i[1:0], i[1:0]});
			wr(dmc_pkg::APB_FRAME_DIV, 32'h4);
			while (cyc < SU - 8) @(posedge sys_clk_in);
			chk(running, 0);
			for (k = 0; k < 20 && running !== 1'b1; k++) @(posedge sys_clk_in);
			tmo(k, 20);
			chk(ctrl_mode, 0);
			chk(speed, i < 2 ? dmc_pkg::SPD_SINGLE : i == 2 ? dmc_pkg::SPD_DOUBLE : dmc_pkg::SPD_QUAD);
			chk(deemph, i == 1);
			chk(format, i);
			chk(osr, i < 2 ? dmc_pkg::OSR_SINGLE : i == 2 ? dmc_pkg::OSR_DOUBLE : dmc_pkg::OSR_QUAD);
			chk({auto_mute, fast_filter}, 2'h3);
			chk(link.serial_audio_line, 0);
			chk(atten >= 8'hfe, 1);
			for (k = 0; k < 3000 && atten !== dmc_pkg::ATTEN_0DB; k++) @(posedge sys_clk_in);
			tmo(k, 3000);
			chk(k >= 2000, 1);
			chk({ratio_ok, ratio}, 13'h8);
			// zero data since reset: auto-muted, lines at the detected level
			apb(1'b0, dmc_pkg::APB_AUDIO, 32'h0, rd, e);
			chk(rd[2:1], 2'h0);
			wr(dmc_pkg::APB_AUDIO, 32'h1);
			repeat (12) @(posedge sys_clk_in);
			apb(1'b0, dmc_pkg::APB_AUDIO, 32'h0, rd, e);
			chk(rd[2:0], 3'h7);
			wr(dmc_pkg::APB_STRAP, {28'h0, ~i[1:0], ~i[1:0]});
			repeat (2) @(posedge sys_clk_in);
			chk({speed, format}, {x_spd, i[2:0]});
		end
		// register control takeover, bias high so active-high polarity is detected
		rst(2'h3);
		cprd(dmc_pkg::REG_POWER, rd);
		chk(rd, dmc_pkg::POWER_DEFAULT);
		cprd(dmc_pkg::REG_MODE, rd);
		chk(rd, dmc_pkg::MODE_DEFAULT);
		apb(1'b0, 8'h14, 32'h0, rd, e);
		chk({e, rd[30:0]}, 32'h80000000);
		cpw(dmc_pkg::REG_POWER, 8'h81);
		while (cyc < SU + 16) @(posedge sys_clk_in);
		chk({ctrl_mode, running}, 2'h2);
		apb(1'b0, dmc_pkg::APB_AUDIO, 32'h0, rd, e);
		chk(rd[2:1], 2'h3);
		cpw(dmc_pkg::REG_MUTE, {6'h0, dmc_pkg::MPOL_ACT_LOW});
		apb(1'b0, dmc_pkg::APB_AUDIO, 32'h0, rd, e);
		chk(rd[2:1], 2'h0);
		cpw(dmc_pkg::REG_MODE, {3'h0, dmc_pkg::FMT_RJ20, dmc_pkg::SPD_QUAD});
		chk({speed, format, osr}, {dmc_pkg::SPD_QUAD, dmc_pkg::FMT_RJ20, dmc_pkg::OSR_QUAD});
		cpw(dmc_pkg::REG_POWER, 8'h80);
		repeat (2) @(posedge sys_clk_in);
		chk({running, atten}, {1'b1, dmc_pkg::ATTEN_0DB});
		chk({deemph, auto_mute, fast_filter}, 3'h0);
		apb(1'b0, dmc_pkg::APB_AUDIO, 32'h0, rd, e);
		chk(rd[2:1], 2'h3);
		// ratio legality per speed, format and frame length
		for (i = 0; i < 6; i++) begin
			cpw(dmc_pkg::REG_MODE, {3'h0, t_fmt[i], t_spd[i]});
			wr(dmc_pkg::APB_FRAME_DIV, {24'h0, t_half[i]});
			for (k = 0; k < 2000 && ratio !== {3'h0, t_half[i], 1'b0}; k++) @(posedge sys_clk_in);
			tmo(k, 2000);
			chk(ratio_ok, t_ok[i]);
		end
		// divider on: quad 256x becomes legal
		cpw(dmc_pkg::REG_POWER, 8'h90);
		cpw(dmc_pkg::REG_MODE, {3'h0, dmc_pkg::FMT_RJ20, dmc_pkg::SPD_QUAD});
		wr(dmc_pkg::APB_FRAME_DIV, 32'h80);
		for (k = 0; k < 2000 && ratio !== 12'h100; k++) @(posedge sys_clk_in);
		tmo(k, 2000);
		chk(ratio_ok, 1);
		cprd(dmc_pkg::REG_STATUS, rd);
		chk(rd, 32'h3b);
		give_verdict();
	end
endmodule
